// ### rtl/bilps_pkg.sv
// constants and types for the boot image loader and pll select block
// Notes on behaviour
// - while reset pin low, hold tile in reset and pull down all gpio pins
// - after reset release, run internal reset, boot 15 to 150 us later
// - security bit 5 set boots from otp, clear boots from serial flash
// - read 32-bit length s in words, then exactly 4*s program bytes
// - then read 32-bit trailer; skip value disables crc check, else expected crc
// - length and trailer words assembled least significant byte first
// - program placed from lowest ram address, execution starts there
// - crc covers length word and program bytes, never the trailer
// - reflected poly EDB88320, preset all ones, final value inverted
// - boot flash reached through tile 0 ports over quad spi
// - mode pins pick pll ratio 40/16/8/4, feedback 159/63/31/15, od 1, r 0
// - tile clock is osc times (f+1)/2 over (r+1) over (od+1)
// - software may rewrite od, f and r through the pll register after boot
package bilps_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BOOT_DELAY_US = 15;
  localparam int unsigned BOOT_DELAY_CYC = BOOT_DELAY_US * CLK_MHZ;
  localparam int unsigned SEC_BOOT_BIT = 5;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam int unsigned RAM_AW = 16;
  // register offsets
  localparam logic [3:0] REG_PLL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_SEC = 4'h2;
  localparam logic [3:0] REG_LEN = 4'h3;
  // pll field positions
  localparam int unsigned PLL_R_LSB = 0;
  localparam int unsigned PLL_F_LSB = 8;
  localparam int unsigned PLL_OD_LSB = 23;
  localparam logic [1:0] MODE_R40 = 2'h0;
  localparam logic [1:0] MODE_R16 = 2'h3;
  localparam logic [1:0] MODE_R8 = 2'h2;
  localparam logic [1:0] MODE_R4 = 2'h1;
  localparam logic [11:0] F_R40 = 12'h09F;
  localparam logic [11:0] F_R16 = 12'h03F;
  localparam logic [11:0] F_R8 = 12'h01F;
  localparam logic [11:0] F_R4 = 12'h00F;
  localparam logic [2:0] OD_RST = 3'h1;
  localparam logic [5:0] R_RST = 6'h00;
  typedef enum logic [2:0] {
    BILPS_IDLE = 3'b000,
    BILPS_WAIT = 3'b001,
    BILPS_LEN = 3'b010,
    BILPS_PROG = 3'b011,
    BILPS_TRAIL = 3'b100,
    BILPS_RUN = 3'b101,
    BILPS_FAIL = 3'b110
  } bilps_state_e;
endpackage : bilps_pkg

// ### rtl/bilps_top.sv
// boot sequencer: reset hold, source select, image load, crc check, pll mode
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module bilps_top
  import bilps_pkg::*;
#(
  parameter int unsigned BOOT_DELAY = BOOT_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_rst_n,
  input wire logic [1:0] mode_pins,
  input wire logic [31:0] security_word,
  input wire logic [7:0] src_byte,
  input wire logic src_valid,
  output logic src_ready,
  output logic src_from_otp,
  output logic gpio_pulldown_en,
  output logic tile_rst,
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic run_start,
  output logic [RAM_AW-1:0] run_pc,
  output logic boot_fail,
  output logic [2:0] pll_output_divider,
  output logic [11:0] pll_feedback,
  output logic [5:0] pll_ref_div,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  bilps_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] len_q, len_d;
  logic [31:0] sh_q, sh_d;
  logic [1:0] bi_q, bi_d;
  logic [31:0] crc_q, crc_d;
  logic [RAM_AW-1:0] wa_q, wa_d;
  logic we_q, we_d;
  logic [31:0] wd_q, wd_d;
  logic run_q, run_d, fail_q, fail_d, trst_q, trst_d, pd_q, pd_d, otp_q, otp_d, rdy_q, rdy_d;
  logic [2:0] od_q, od_d;
  logic [11:0] f_q, f_d;
  logic [5:0] r_q, r_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] word_nx;
  logic take;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_byte

  always_comb begin
    take = rdy_q && src_valid;
    word_nx = {src_byte, sh_q[31:8]};
    st_d = st_q;
    cnt_d = cnt_q;
    len_d = len_q;
    sh_d = sh_q;
    bi_d = bi_q;
    crc_d = crc_q;
    wa_d = wa_q;
    we_d = 1'b0;
    wd_d = wd_q;
    run_d = run_q;
    fail_d = fail_q;
    trst_d = trst_q;
    pd_d = pd_q;
    otp_d = otp_q;
    rdy_d = 1'b0;
    case (st_q)
      BILPS_IDLE: begin
        trst_d = 1'b1;
        pd_d = 1'b1;
        cnt_d = 32'h00000000;
        if (chip_rst_n) begin
          st_d = BILPS_WAIT;
        end
      end
      BILPS_WAIT: begin
        pd_d = 1'b0;
        cnt_d = cnt_q + 32'h00000001;
        if (cnt_q >= BOOT_DELAY - 1) begin
          otp_d = security_word[SEC_BOOT_BIT];
          crc_d = CRC_INIT;
          bi_d = 2'h0;
          cnt_d = 32'h00000000;
          rdy_d = 1'b1;
          st_d = BILPS_LEN;
        end
      end
      BILPS_LEN: begin
        rdy_d = 1'b1;
        if (take) begin
          crc_d = crc_byte(crc_q, src_byte);
          sh_d = word_nx;
          bi_d = bi_q + 2'h1;
          if (bi_q == 2'h3) begin
            len_d = word_nx;
            wa_d = RAM_BASE;
            st_d = (word_nx == 32'h00000000) ? BILPS_TRAIL : BILPS_PROG;
          end
        end
      end
      BILPS_PROG: begin
        rdy_d = 1'b1;
        if (take) begin
          crc_d = crc_byte(crc_q, src_byte);
          sh_d = word_nx;
          bi_d = bi_q + 2'h1;
          if (bi_q == 2'h3) begin
            we_d = 1'b1;
            wd_d = word_nx;
            cnt_d = cnt_q + 32'h00000001;
            if (cnt_q != 32'h00000000) begin
              wa_d = wa_q + {{(RAM_AW-1){1'b0}}, 1'b1};
            end
            if (cnt_q + 32'h00000001 == len_q) begin
              st_d = BILPS_TRAIL;
            end
          end
        end
      end
      BILPS_TRAIL: begin
        rdy_d = 1'b1;
        if (take) begin
          sh_d = word_nx;
          bi_d = bi_q + 2'h1;
          if (bi_q == 2'h3) begin
            rdy_d = 1'b0;
            if (word_nx == CRC_SKIP || word_nx == ~crc_q) begin
              run_d = 1'b1;
              trst_d = 1'b0;
              st_d = BILPS_RUN;
            end else begin
              fail_d = 1'b1;
              st_d = BILPS_FAIL;
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (!chip_rst_n) begin
      st_d = BILPS_IDLE;
      trst_d = 1'b1;
      pd_d = 1'b1;
      run_d = 1'b0;
      fail_d = 1'b0;
      rdy_d = 1'b0;
      we_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= BILPS_IDLE;
      cnt_q <= 32'h00000000;
      len_q <= 32'h00000000;
      sh_q <= 32'h00000000;
      bi_q <= 2'h0;
      crc_q <= CRC_INIT;
      wa_q <= RAM_BASE;
      we_q <= 1'b0;
      wd_q <= 32'h00000000;
      run_q <= 1'b0;
      fail_q <= 1'b0;
      trst_q <= 1'b1;
      pd_q <= 1'b1;
      otp_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      sh_q <= sh_d;
      bi_q <= bi_d;
      crc_q <= crc_d;
      wa_q <= wa_d;
      we_q <= we_d;
      wd_q <= wd_d;
      run_q <= run_d;
      fail_q <= fail_d;
      trst_q <= trst_d;
      pd_q <= pd_d;
      otp_q <= otp_d;
      rdy_q <= rdy_d;
    end
  end

  // pll settings and register port
  always_comb begin
    od_d = od_q;
    f_d = f_q;
    r_d = r_q;
    rd_d = 32'h00000000;
    if (st_q == BILPS_IDLE) begin
      // mode pin pll defaults, pins assumed static
      od_d = OD_RST;
      r_d = R_RST;
      case (mode_pins)
        MODE_R40: f_d = F_R40;
        MODE_R16: f_d = F_R16;
        MODE_R8: f_d = F_R8;
        default: f_d = F_R4;
      endcase
    end else if (reg_wr && reg_addr == REG_PLL) begin
      // software pll rewrite, range kept by software
      od_d = reg_wdata[PLL_OD_LSB +: 3];
      f_d = reg_wdata[PLL_F_LSB +: 12];
      r_d = reg_wdata[PLL_R_LSB +: 6];
    end
    if (reg_rd) begin
      if (reg_addr == REG_PLL) begin
        rd_d = 32'h00000000;
        rd_d[PLL_OD_LSB +: 3] = od_q;
        rd_d[PLL_F_LSB +: 12] = f_q;
        rd_d[PLL_R_LSB +: 6] = r_q;
      end else if (reg_addr == REG_STATUS) begin
        rd_d = {25'h0000000, otp_q, fail_q, run_q, 1'b0, st_q};
      end else if (reg_addr == REG_SEC) begin
        rd_d = security_word;
      end else if (reg_addr == REG_LEN) begin
        rd_d = len_q;
      end else begin
        rd_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      od_q <= OD_RST;
      f_q <= F_R40;
      r_q <= R_RST;
      rd_q <= 32'h00000000;
    end else begin
      od_q <= od_d;
      f_q <= f_d;
      r_q <= r_d;
      rd_q <= rd_d;
    end
  end

  // byte source stands for the tile 0 quad spi port path
  assign src_ready = rdy_q;
  assign src_from_otp = otp_q;
  assign gpio_pulldown_en = pd_q;
  assign tile_rst = trst_q;
  assign ram_we = we_q;
  assign ram_addr = wa_q;
  assign ram_wdata = wd_q;
  assign run_start = run_q;
  assign run_pc = RAM_BASE;
  assign boot_fail = fail_q;
  // ratio formed by clock generator from these fields
  assign pll_output_divider = od_q;
  assign pll_feedback = f_q;
  assign pll_ref_div = r_q;
  assign reg_rdata = rd_q;
endmodule : bilps_top

// ### tb/bilps_flash_model.sv
// boot flash model: serves queued image bytes, each held until taken
`timescale 1ns/1ps
module bilps_flash_model (
  input wire logic clk,
  input wire logic chip_rst_n,
  input wire logic src_ready,
  output logic [7:0] src_byte,
  output logic src_valid
);
  logic [7:0] img [$];
  int stall = 0;
  int gap = 0;
  initial src_valid = 1'b0;
  initial src_byte = 8'h5A;
  // flash bytes; released data toggles so stale bytes never match
  always @(posedge clk) begin
    if (!chip_rst_n) begin
      src_valid <= 1'b0;
      src_byte <= ~src_byte;
    end else if (src_valid && src_ready) begin
      void'(img.pop_front());
      gap <= stall;
      src_valid <= stall == 0 && img.size() > 0;
      src_byte <= (stall == 0 && img.size() > 0) ? img[0] : ~src_byte;
    end else if (!src_valid && (gap > 0 || img.size() == 0)) begin
      gap <= gap > 0 ? gap - 1 : 0;
      src_byte <= ~src_byte;
    end else if (!src_valid) begin
      src_valid <= 1'b1;
      src_byte <= img[0];
    end
  end
endmodule : bilps_flash_model

// ### tb/bilps_top_sva.sv
// assertion checker for the boot sequencer ports
`timescale 1ns/1ps
module bilps_top_sva
  import bilps_pkg::*;
#(
  parameter int unsigned BOOT_DELAY = BOOT_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_rst_n,
  input wire logic [1:0] mode_pins,
  input wire logic [31:0] security_word,
  input wire logic src_ready,
  input wire logic src_from_otp,
  input wire logic gpio_pulldown_en,
  input wire logic tile_rst,
  input wire logic ram_we,
  input wire logic run_start,
  input wire logic [RAM_AW-1:0] run_pc,
  input wire logic boot_fail,
  input wire logic [11:0] pll_feedback
);
  localparam logic [11:0] FT [4] = '{12'h09F, 12'h00F, 12'h01F, 12'h03F};
  int unsigned hi_q;
  // saturates so the upper-bound check fires once per release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hi_q <= 0;
    else if (!chip_rst_n) hi_q <= 0;
    else if (hi_q < BOOT_DELAY + 8) hi_q <= hi_q + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_hold;
    !chip_rst_n |=> gpio_pulldown_en && tile_rst && !src_ready && !run_start;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pin not obeyed");
  property p_ready_min;
    src_ready |-> hi_q >= BOOT_DELAY;
  endproperty
  a_ready_min: assert property (p_ready_min) else $error("boot began early");
  property p_ready_max;
    hi_q == BOOT_DELAY + 4 |-> src_ready;
  endproperty
  a_ready_max: assert property (p_ready_max) else $error("boot began late");
  property p_otp;
    src_ready |-> src_from_otp == security_word[SEC_BOOT_BIT];
  endproperty
  a_otp: assert property (p_otp) else $error("wrong boot source");
  property p_pc;
    run_start |-> run_pc == RAM_BASE && !tile_rst && !boot_fail;
  endproperty
  a_pc: assert property (p_pc) else $error("start address wrong");
  property p_fail;
    boot_fail |-> !run_start && tile_rst;
  endproperty
  a_fail: assert property (p_fail) else $error("failed image started");
  property p_mode;
    !chip_rst_n ##1 !chip_rst_n |=> pll_feedback == FT[$past(mode_pins)];
  endproperty
  a_mode: assert property (p_mode) else $error("pll strap value wrong");
  property p_ramwe;
    ram_we |=> !ram_we [*3];
  endproperty
  a_ramwe: assert property (p_ramwe) else $error("word written too soon");
  c_run: cover property (run_start);
  c_fail: cover property (boot_fail);
  c_we: cover property (ram_we);
endmodule : bilps_top_sva
bind bilps_top bilps_top_sva #(.BOOT_DELAY(BOOT_DELAY)) u_sva (.clk(clk), .rst(rst), .chip_rst_n(chip_rst_n),
  .mode_pins(mode_pins), .security_word(security_word), .src_ready(src_ready), .src_from_otp(src_from_otp),
  .gpio_pulldown_en(gpio_pulldown_en), .tile_rst(tile_rst), .ram_we(ram_we), .run_start(run_start),
  .run_pc(run_pc), .boot_fail(boot_fail), .pll_feedback(pll_feedback));

// ### tb/tb.sv
// self-checking bench: image boots, pll straps, register access
`timescale 1ns/1ps
module tb;
  import bilps_pkg::*;
  logic clk = 0, rst = 1, chip_rst_n = 0, reg_wr = 0, reg_rd = 0, src_valid, src_ready, src_from_otp;
  logic gpio_pulldown_en, tile_rst, ram_we, run_start, boot_fail;
  logic [1:0] mode_pins = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] src_byte;
  logic [31:0] security_word = 0, reg_wdata = 0, reg_rdata, ram_wdata;
  logic [RAM_AW-1:0] ram_addr, run_pc;
  logic [2:0] pll_output_divider;
  logic [11:0] pll_feedback;
  logic [5:0] pll_ref_div;
  logic [31:0] mem [16];
  int num_errors = 0, cmp_count = 0, nwr = 0;
  localparam logic [11:0] FT [4] = '{12'h09F, 12'h00F, 12'h01F, 12'h03F};
  always #2.5 clk = ~clk;
  bilps_top #(.BOOT_DELAY(4)) uut (.clk(clk), .rst(rst), .chip_rst_n(chip_rst_n), .mode_pins(mode_pins),
    .security_word(security_word), .src_byte(src_byte), .src_valid(src_valid), .src_ready(src_ready),
    .src_from_otp(src_from_otp), .gpio_pulldown_en(gpio_pulldown_en), .tile_rst(tile_rst), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .run_start(run_start), .run_pc(run_pc), .boot_fail(boot_fail),
    .pll_output_divider(pll_output_divider), .pll_feedback(pll_feedback), .pll_ref_div(pll_ref_div),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bilps_flash_model fm (.clk(clk), .chip_rst_n(chip_rst_n), .src_ready(src_ready), .src_byte(src_byte),
    .src_valid(src_valid));
  always @(posedge clk) begin
    if (ram_we) begin
      mem[ram_addr[3:0]] <= ram_wdata;
      nwr <= nwr + 1;
    end
  end
  function automatic logic [31:0] crc(input logic [7:0] q [$]);
    logic [31:0] c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // kind 0 good crc, 1 skip value, 2 corrupted crc
  task automatic boot(input logic [1:0] m, input logic sec, input int s, input int kind);
    logic [7:0] b [$];
    logic [31:0] w;
    mode_pins <= m;
    security_word <= {26'h0, sec, 5'h0};
    chip_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    nwr = 0;
    for (int i = 0; i <= s; i++) begin
      w = i == 0 ? s : 32'hC0DE0000 + i;
      for (int k = 0; k < 4; k++) b.push_back(w[8*k +: 8]);
    end
    w = kind == 1 ? CRC_SKIP : crc(b) ^ {32{kind == 2}};
    for (int k = 0; k < 4; k++) b.push_back(w[8*k +: 8]);
    fm.img = b;
    @(negedge clk);
    chk(gpio_pulldown_en & tile_rst, 1);
    chk({pll_output_divider, pll_feedback, pll_ref_div}, {3'h1, FT[m], 6'h0});
    @(posedge clk);
    chip_rst_n <= 1'b1;
    for (int i = 0; i < 300 && run_start !== 1'b1 && boot_fail !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk({run_start, boot_fail, src_from_otp}, {kind != 2, kind == 2, sec});
    chk(nwr, s);
    for (int i = 0; i < s; i++) chk(mem[i], 32'hC0DE0001 + i);
    @(posedge clk);
  endtask : boot
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    boot(2'h0, 1'b0, 2, 0);
    fm.stall = 2;
    boot(2'h3, 1'b0, 1, 1);
    boot(2'h2, 1'b0, 1, 2);
    fm.stall = 0;
    boot(2'h1, 1'b1, 0, 0);
    wr(REG_PLL, 32'h02812307);
    @(negedge clk);
    chk({pll_output_divider, pll_feedback, pll_ref_div}, {3'h5, 12'h123, 6'h07});
    @(posedge clk);
    rd(REG_PLL, 32'h02812307);
    rd(4'hF, 32'h0);
    rd(REG_SEC, 32'h20);
    rd(REG_STATUS, {25'h0, 1'b1, 1'b0, 1'b1, 1'b0, BILPS_RUN});
    rd(REG_LEN, 32'h0);
    chip_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr(REG_PLL, 32'h02812307);
    rd(REG_PLL, {6'h00, OD_RST, 3'h0, F_R4, 2'h0, R_RST});
    give_verdict();
  end
endmodule : tb
